// ==== design/gate_ctrl_pkg.sv ====
// How it works
// - Shift serial input on clock rise in frame
// - Serial output changes on clock fall
// - Select low drives output, accepts input
// - Shifted word commits only on select rise
// - Select high floats output, ignores clock
// - Gate on: no reset, no shutdown, pin or bit
// - Serial gate bits clear on every reset
// - All six gate bits in one register
// - One mask bit per channel ignores detectors
// - Per-channel ground and battery threshold selects
// - Per-channel on and off blank time selects
// - Two shared retry timers (short, long) re-enable shut channels
// - Battery check on-state, ground/open check off-state
// - Six identical independent channel instances
// - Valid reset restores power-on register values
// - Valid reset holds all gates low
// - Valid reset clears faults, sets reset flag
// - Supply and heat flags mirror detectors live
// - Reset glitch filter rejects short low pulses
// - Three latched fault bits per channel
// - Fault bit holds until transfer after clearing
// - Detection off in reset or when masked
package gate_ctrl_pkg;
    localparam int CLK_KHZ = 20000;
    localparam int CH_N = 6;
    localparam int FRAME_W = 16;
    localparam int ADDR_W = 4;
    localparam int CFG_W = 12;
    localparam int SYNC_W = 30;
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 30'h0000_0009;
    // -----------------------------
    // Frame addresses
    // -----------------------------
    localparam logic [ADDR_W-1:0] ADDR_GATE = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CFG0 = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_RD1 = 4'h9;
    // -----------------------------
    // Configuration fields
    // -----------------------------
    localparam int CFG_SG = 0;
    localparam int CFG_SB_LSB = 1;
    localparam int CFG_TON_LSB = 4;
    localparam int CFG_TOF_LSB = 6;
    localparam int CFG_NPD = 8;
    localparam int CFG_RT0 = 10;
    localparam int CFG_RT1 = 11;
    localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;
    localparam logic [CH_N-1:0] GATE_RESET = 6'h00;
    localparam logic [CH_N-1:0] MASK_RESET = 6'h00;
    localparam int FLT_STB = 0;
    localparam int FLT_STG = 1;
    localparam int FLT_OPEN = 2;
    // -----------------------------
    // Timing
    // -----------------------------
    localparam int RESET_FILTER_NS = 2000;
    localparam int RESET_FILTER_CYC = (RESET_FILTER_NS * CLK_KHZ + 999999) / 1000000;
    localparam int FILTER_NS = 2000;
    localparam int FILTER_CYC = FILTER_NS * CLK_KHZ / 1000000;
    localparam int TON0_US = 5;
    localparam int TON1_US = 14;
    localparam int TON2_US = 28;
    localparam int TON3_US = 56;
    localparam int TOF0_US = 80;
    localparam int TOF1_US = 140;
    localparam int TOF2_US = 280;
    localparam int TOF3_US = 4000;
    localparam int RETRY_SHORT_US = 10000;
    localparam int RETRY_LONG_US = 55000;
    localparam int TON0_CYC = TON0_US * CLK_KHZ / 1000;
    localparam int TON1_CYC = TON1_US * CLK_KHZ / 1000;
    localparam int TON2_CYC = TON2_US * CLK_KHZ / 1000;
    localparam int TON3_CYC = TON3_US * CLK_KHZ / 1000;
    localparam int TOF0_CYC = TOF0_US * CLK_KHZ / 1000;
    localparam int TOF1_CYC = TOF1_US * CLK_KHZ / 1000;
    localparam int TOF2_CYC = TOF2_US * CLK_KHZ / 1000;
    localparam int TOF3_CYC = TOF3_US * CLK_KHZ / 1000;
    localparam int RETRY_SHORT_CYC = RETRY_SHORT_US * CLK_KHZ / 1000;
    localparam int RETRY_LONG_CYC = RETRY_LONG_US * CLK_KHZ / 1000;
    localparam int BLANK_W = 17;
    localparam int FILT_W = 6;
    localparam int RF_W = 8;
    localparam int RETRY_W = 21;
endpackage

// ==== design/chan_link_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface chan_link_if;
    logic command;
    logic serialBit;
    logic resetHold;
    logic maskBit;
    logic [gate_ctrl_pkg::CFG_W-1:0] cfg;
    logic stbSeen;
    logic stgSeen;
    logic openSeen;
    logic retryShort;
    logic retryLong;
    logic gateOn;
    logic shutdown;
    logic [2:0] faultState;
    modport top (output command, serialBit, resetHold, maskBit, cfg, stbSeen,
                 stgSeen, openSeen, retryShort, retryLong,
                 input gateOn, shutdown, faultState);
    modport chan (input command, serialBit, resetHold, maskBit, cfg, stbSeen,
                  stgSeen, openSeen, retryShort, retryLong,
                  output gateOn, shutdown, faultState);
endinterface
`default_nettype wire

// ==== design/gate_channel.sv ====
`timescale 1ns/1ns
`default_nettype none
module gate_channel #(
    parameter int OffLongCyc = gate_ctrl_pkg::TOF3_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    chan_link_if.chan link
);
    import gate_ctrl_pkg::*;

    typedef struct packed {
        logic gateOn;
        logic shut;
        logic [2:0] fault;
        logic serialPrev;
        logic [BLANK_W-1:0] blank;
        logic [FILT_W-1:0] filt;
    } chan_s;

    chan_s st_r;
    chan_s st_nxt;
    logic [BLANK_W-1:0] onBlank;
    logic [BLANK_W-1:0] offBlank;
    logic gateNext;
    logic seen;

    // -----------------------------
    // Next state
    // -----------------------------
    always_comb
    begin
        st_nxt = st_r;
        gateNext = 1'b0;
        seen = 1'b0;
        case (link.cfg[CFG_TON_LSB +: 2])
            2'h0: onBlank = BLANK_W'(TON0_CYC);
            2'h1: onBlank = BLANK_W'(TON1_CYC);
            2'h2: onBlank = BLANK_W'(TON2_CYC);
            default: onBlank = BLANK_W'(TON3_CYC);
        endcase
        case (link.cfg[CFG_TOF_LSB +: 2])
            2'h0: offBlank = BLANK_W'(TOF0_CYC);
            2'h1: offBlank = BLANK_W'(TOF1_CYC);
            2'h2: offBlank = BLANK_W'(TOF2_CYC);
            default: offBlank = BLANK_W'(OffLongCyc);
        endcase
        if (link.resetHold)
        begin
            st_nxt = '0;
        end
        else
        begin
            // Serial on-then-off toggle releases a shutdown
            if (st_r.serialPrev && !link.serialBit)
                st_nxt.shut = 1'b0;
            if (link.cfg[CFG_RT1] &&
                (link.cfg[CFG_RT0] ? link.retryLong : link.retryShort))
                st_nxt.shut = 1'b0;
            gateNext = link.command && !st_nxt.shut;
            st_nxt.gateOn = gateNext;
            st_nxt.serialPrev = link.serialBit;
            seen = st_r.gateOn ? link.stbSeen
                               : (link.stgSeen || link.openSeen);
            if (gateNext != st_r.gateOn)
            begin
                st_nxt.blank = gateNext ? onBlank : offBlank;
                st_nxt.filt = '0;
            end
            else if (st_r.blank != '0)
            begin
                st_nxt.blank = st_r.blank - 1'b1;
                // Fault state only clears at the end of a blank time
                if (st_r.blank == BLANK_W'(1) && !link.maskBit)
                begin
                    if (st_r.gateOn && !link.stbSeen)
                        st_nxt.fault[FLT_STB] = 1'b0;
                    if (!st_r.gateOn && !link.stgSeen)
                        st_nxt.fault[FLT_STG] = 1'b0;
                    if (!st_r.gateOn && !link.openSeen)
                        st_nxt.fault[FLT_OPEN] = 1'b0;
                end
            end
            else if (!link.maskBit && seen)
            begin
                if (st_r.filt != FILT_W'(FILTER_CYC))
                    st_nxt.filt = st_r.filt + 1'b1;
                if (st_r.filt == FILT_W'(FILTER_CYC - 1))
                begin
                    if (st_r.gateOn)
                    begin
                        st_nxt.fault[FLT_STB] = 1'b1;
                        st_nxt.shut = 1'b1;
                        st_nxt.gateOn = 1'b0;
                        // A shutdown is a turn-off too, so the off blank starts here
                        st_nxt.blank = offBlank;
                        st_nxt.filt = '0;
                    end
                    else
                    begin
                        st_nxt.fault[FLT_STG] = link.stgSeen | st_r.fault[FLT_STG];
                        st_nxt.fault[FLT_OPEN] = link.openSeen | st_r.fault[FLT_OPEN];
                    end
                end
            end
            else
            begin
                st_nxt.filt = '0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign link.gateOn = st_r.gateOn;
    assign link.shutdown = st_r.shut;
    assign link.faultState = st_r.fault;
endmodule // gate_channel
`default_nettype wire

// ==== design/six_channel_gate_control_logic.sv ====
`timescale 1ns/1ns
`default_nettype none
module six_channel_gate_control_logic #(
    parameter int OffLongCyc = gate_ctrl_pkg::TOF3_CYC,
    parameter int RetryShortCyc = gate_ctrl_pkg::RETRY_SHORT_CYC,
    parameter int RetryLongCyc = gate_ctrl_pkg::RETRY_LONG_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic chipResetLow,
    input wire logic selectLow,
    input wire logic serialClk,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEn,
    input wire logic [gate_ctrl_pkg::CH_N-1:0] channelCommandPin,
    input wire logic [gate_ctrl_pkg::CH_N-1:0] drainHighDetect,
    input wire logic [gate_ctrl_pkg::CH_N-1:0] drainLowDetect,
    input wire logic [gate_ctrl_pkg::CH_N-1:0] drainOpenDetect,
    input wire logic supplyLowDetect,
    input wire logic overheatDetect,
    output logic [gate_ctrl_pkg::CH_N-1:0] gateOutput,
    output logic [3*gate_ctrl_pkg::CH_N-1:0] stbLevel,
    output logic [gate_ctrl_pkg::CH_N-1:0] stgLevel,
    output logic [gate_ctrl_pkg::CH_N-1:0] pullDownOff
);
    import gate_ctrl_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] syncA;
        logic [SYNC_W-1:0] syncB;
        logic sckPrev;
        logic selPrev;
        logic [RF_W-1:0] rstCnt;
        logic chipReset;
        logic [FRAME_W-1:0] shiftIn;
        logic [FRAME_W-1:0] shiftOut;
        logic [4:0] bitCnt;
        logic soBit;
        logic soEn;
        logic [CH_N-1:0] gateBits;
        logic [CH_N-1:0] mask;
        logic [CH_N-1:0][CFG_W-1:0] cfg;
        logic [3*CH_N-1:0] report;
        logic logicResetFlag;
        logic readSel;
        logic [RETRY_W-1:0] shortCnt;
        logic [RETRY_W-1:0] longCnt;
        logic tickShort;
        logic tickLong;
        logic [CH_N-1:0] command;
        logic [CH_N-1:0] gateOut;
    } top_s;

    top_s r;
    top_s n;
    logic [SYNC_W-1:0] asyncIn;
    logic [CH_N-1:0] gateOnVec;
    logic [CH_N-1:0] shutVec;
    logic [3*CH_N-1:0] faultVec;
    logic selL;
    logic sck;
    logic si;
    logic rstPin;
    logic [CH_N-1:0] inPins;
    logic [CH_N-1:0] stbD;
    logic [CH_N-1:0] stgD;
    logic [CH_N-1:0] opD;
    logic supplyLow;
    logic overheat;
    logic [ADDR_W-1:0] addr;
    logic [CFG_W-1:0] data;
    logic [FRAME_W-1:0] readWord;

    // Everything from the pins, packed for the synchroniser
    assign asyncIn = {supplyLowDetect, overheatDetect, drainOpenDetect,
                      drainLowDetect, drainHighDetect, channelCommandPin,
                      chipResetLow, serialIn, serialClk, selectLow};

    // -----------------------------
    // Synchronised views
    // -----------------------------
    always_comb
    begin
        selL = r.syncB[0];
        sck = r.syncB[1];
        si = r.syncB[2];
        rstPin = r.syncB[3];
        inPins = r.syncB[4 +: CH_N];
        stbD = r.syncB[10 +: CH_N];
        stgD = r.syncB[16 +: CH_N];
        opD = r.syncB[22 +: CH_N];
        overheat = r.syncB[28];
        supplyLow = r.syncB[29];
        addr = r.shiftIn[FRAME_W-1 -: ADDR_W];
        data = r.shiftIn[CFG_W-1:0];
        // Supply and heat flags are live, not latched
        readWord = {r.logicResetFlag, supplyLow, overheat, r.readSel, 3'b000,
                    r.readSel ? r.report[17:9] : r.report[8:0]};
    end

    // -----------------------------
    // Next state
    // -----------------------------
    always_comb
    begin
        n = r;
        n.syncA = asyncIn;
        n.syncB = r.syncA;
        n.sckPrev = sck;
        n.selPrev = selL;
        n.tickShort = 1'b0;
        n.tickLong = 1'b0;
        // Reset filter: a pulse shorter than the count is ignored
        if (!rstPin)
        begin
            if (r.rstCnt != RF_W'(RESET_FILTER_CYC))
                n.rstCnt = r.rstCnt + 1'b1;
            else
                n.chipReset = 1'b1;
        end
        else
        begin
            n.rstCnt = '0;
            n.chipReset = 1'b0;
        end
        if (r.chipReset)
        begin
            n.gateBits = GATE_RESET;
            n.mask = MASK_RESET;
            n.cfg = {CH_N{CFG_RESET}};
            n.report = '0;
            n.logicResetFlag = 1'b1;
            n.readSel = 1'b0;
            n.bitCnt = '0;
            n.soEn = 1'b0;
            n.soBit = 1'b0;
        end
        else if (!selL)
        begin
            n.soEn = 1'b1;
            if (r.selPrev)
            begin
                // Frame start: first bit is valid before any clock edge
                n.shiftOut = readWord;
                n.soBit = readWord[FRAME_W-1];
                n.bitCnt = '0;
            end
            else
            begin
                if (sck && !r.sckPrev)
                begin
                    n.shiftIn = {r.shiftIn[FRAME_W-2:0], si};
                    if (r.bitCnt != 5'h1f)
                        n.bitCnt = r.bitCnt + 1'b1;
                end
                if (!sck && r.sckPrev)
                begin
                    n.shiftOut = {r.shiftOut[FRAME_W-2:0], 1'b0};
                    n.soBit = r.shiftOut[FRAME_W-2];
                end
            end
        end
        else
        begin
            n.soEn = 1'b0;
            if (!r.selPrev)
            begin
                // A frame of the wrong length writes no register; fault and reset flags still update
                if (r.bitCnt == 5'(FRAME_W))
                begin
                    if (addr == ADDR_GATE)
                        n.gateBits = data[CH_N-1:0];
                    if (addr == ADDR_MASK)
                        n.mask = data[CH_N-1:0];
                    for (int k = 0; k < CH_N; k++)
                    begin
                        if (addr == ADDR_CFG0 + ADDR_W'(k))
                            n.cfg[k] = data;
                    end
                    n.readSel = (addr == ADDR_RD1);
                end
                n.report = r.report & faultVec;
                n.logicResetFlag = 1'b0;
            end
        end
        if (!r.chipReset)
            n.report = n.report | faultVec;
        // Shared retry timers run only while some channel is shut
        if (|shutVec)
        begin
            n.shortCnt = r.shortCnt + 1'b1;
            n.longCnt = r.longCnt + 1'b1;
            if (r.shortCnt == RETRY_W'(RetryShortCyc - 1))
            begin
                n.shortCnt = '0;
                n.tickShort = 1'b1;
            end
            if (r.longCnt == RETRY_W'(RetryLongCyc - 1))
            begin
                n.longCnt = '0;
                n.tickLong = 1'b1;
            end
        end
        else
        begin
            n.shortCnt = '0;
            n.longCnt = '0;
        end
        n.command = inPins | r.gateBits;
        n.gateOut = gateOnVec & ~{CH_N{r.chipReset}};
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            r <= '0;
            r.syncA <= SYNC_IDLE;
            r.syncB <= SYNC_IDLE;
            r.selPrev <= 1'b1;
            r.logicResetFlag <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    // -----------------------------
    // Channels
    // -----------------------------
    for (genvar i = 0; i < CH_N; i++)
    begin : g_ch
        chan_link_if link ();
        assign link.command = r.command[i];
        assign link.serialBit = r.gateBits[i];
        assign link.resetHold = r.chipReset;
        assign link.maskBit = r.mask[i];
        assign link.cfg = r.cfg[i];
        assign link.stbSeen = stbD[i];
        assign link.stgSeen = stgD[i];
        assign link.openSeen = opD[i];
        assign link.retryShort = r.tickShort;
        assign link.retryLong = r.tickLong;
        assign gateOnVec[i] = link.gateOn;
        assign shutVec[i] = link.shutdown;
        assign faultVec[3*i +: 3] = link.faultState;
        assign stbLevel[3*i +: 3] = r.cfg[i][CFG_SB_LSB +: 3];
        assign stgLevel[i] = r.cfg[i][CFG_SG];
        assign pullDownOff[i] = r.cfg[i][CFG_NPD];
        gate_channel #(.OffLongCyc(OffLongCyc)) u_ch (
            .ref_clk(ref_clk),
            .arst_n(arst_n),
            .link(link.chan)
        );
    end

    assign serialOut = r.soBit;
    assign serialOutEn = r.soEn;
    assign gateOutput = r.gateOut;
endmodule // six_channel_gate_control_logic
`default_nettype wire

// ==== sim/serial_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
    input wire logic ref_clk,
    output var logic selectLow,
    output var logic serialClk,
    output var logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEn
);
    logic soWire;
    // Push-pull pin floats whenever the device lets go
    assign soWire = serialOutEn ? serialOut : 1'bz;
    initial
    begin
        selectLow = 1'b1;
        serialClk = 1'b0;
        serialIn = 1'b0;
    end
    // ----
    // One frame, first bit MSB; clock 4 cycles low, 4 high
    // ----
    task automatic xfer(input logic [15:0] tx, input int nBits, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge ref_clk);
        selectLow <= 1'b0;
        for (int i = 15; i > 15 - nBits; i--)
        begin
            serialIn <= tx[i];
            repeat (3) @(posedge ref_clk);
            // Sampled mid-cycle so the device's own edge update never races us
            @(negedge ref_clk);
            rx[i] = soWire;
            @(posedge ref_clk);
            serialClk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            serialClk <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        selectLow <= 1'b1;
        // Clock rests low between frames; data falls to its pull-down level
        serialIn <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule // serial_host_model
`default_nettype wire

// ==== sim/six_channel_gate_control_logic_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module six_channel_gate_control_logic_asserts (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic chipResetLow,
    input wire logic selectLow,
    input wire logic serialClk,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic [gate_ctrl_pkg::CH_N-1:0] channelCommandPin,
    input wire logic [gate_ctrl_pkg::CH_N-1:0] drainHighDetect,
    input wire logic [gate_ctrl_pkg::CH_N-1:0] gateOutput,
    input wire logic [3*gate_ctrl_pkg::CH_N-1:0] stbLevel,
    input wire logic [gate_ctrl_pkg::CH_N-1:0] stgLevel,
    input wire logic [gate_ctrl_pkg::CH_N-1:0] pullDownOff
);
    import gate_ctrl_pkg::*;
    // ----
    // Reset pin history, saturating
    // ----
    logic [5:0] lowCnt_r;
    logic [3:0] highCnt_r;
    logic clean_r;
    logic inRst;
    logic live;
    assign inRst = lowCnt_r >= 6'h30;
    assign live = highCnt_r >= 4'h8;
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lowCnt_r <= 6'h00;
            highCnt_r <= 4'h0;
            clean_r <= 1'b1;
        end
        else
        begin
            lowCnt_r <= chipResetLow ? 6'h00 : lowCnt_r + {5'h00, lowCnt_r != 6'h3f};
            highCnt_r <= chipResetLow ? highCnt_r + {3'h0, highCnt_r != 4'hf} : 4'h0;
            // A battery hit may leave channel 0 shut, so stop judging it
            clean_r <= (clean_r | inRst) & ~drainHighDetect[0];
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    property p_floatIdle;
        selectLow [*4] |=> !serialOutEn;
    endproperty
    a_floatIdle: assert property (p_floatIdle) else $error("out driven while idle");
    property p_drive;
        (live && !selectLow) [*5] |=> serialOutEn;
    endproperty
    a_drive: assert property (p_drive) else $error("out not driven in frame");
    property p_edgeOut;
        (!selectLow && serialClk) [*2] |-> $stable(serialOut);
    endproperty
    a_edgeOut: assert property (p_edgeOut) else $error("out moved on high clock");
    property p_commit;
        (live && !selectLow) [*5] |=> $stable({stbLevel, stgLevel, pullDownOff});
    endproperty
    a_commit: assert property (p_commit) else $error("config moved mid frame");
    property p_gateRst;
        inRst |-> gateOutput == 6'h00 && !serialOutEn;
    endproperty
    a_gateRst: assert property (p_gateRst) else $error("gate on in reset");
    property p_cfgRst;
        inRst |=> {stbLevel, stgLevel, pullDownOff} == 30'h0000_0000;
    endproperty
    a_cfgRst: assert property (p_cfgRst) else $error("config kept in reset");
    property p_cmdGate;
        (live && clean_r && channelCommandPin[0]) [*7] |=> gateOutput[0];
    endproperty
    a_cmdGate: assert property (p_cmdGate) else $error("pin did not turn gate on");
    property p_sync;
        $rose(channelCommandPin[0]) |=> $stable(gateOutput[0]) [*2];
    endproperty
    a_sync: assert property (p_sync) else $error("pin reached gate too soon");
    c_rst: cover property (inRst);
    c_shut: cover property ($fell(gateOutput[1]));
    c_frame: cover property ($rose(serialOutEn));
endmodule // six_channel_gate_control_logic_asserts
bind six_channel_gate_control_logic six_channel_gate_control_logic_asserts chk_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .chipResetLow(chipResetLow),
    .selectLow(selectLow), .serialClk(serialClk), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .channelCommandPin(channelCommandPin),
    .drainHighDetect(drainHighDetect), .gateOutput(gateOutput), .stbLevel(stbLevel),
    .stgLevel(stgLevel), .pullDownOff(pullDownOff)
);
`default_nettype wire

// ==== sim/tb_six_channel_gate_control_logic.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_six_channel_gate_control_logic;
    import gate_ctrl_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic chipResetLow = 1'b1;
    logic supplyLowDetect = 1'b0;
    logic overheatDetect = 1'b0;
    logic [CH_N-1:0] channelCommandPin = 6'h00;
    logic [CH_N-1:0] drainHighDetect = 6'h00;
    logic [CH_N-1:0] drainLowDetect = 6'h00;
    logic [CH_N-1:0] drainOpenDetect = 6'h00;
    logic selectLow;
    logic serialClk;
    logic serialIn;
    logic serialOut;
    logic serialOutEn;
    logic [CH_N-1:0] gateOutput;
    logic [CH_N-1:0] stgLevel;
    logic [CH_N-1:0] pullDownOff;
    logic [3*CH_N-1:0] stbLevel;
    logic [15:0] rx;
    int errTotal = 0;
    int nTests = 0;
    int cycleCnt = 0;
    always #25 ref_clk = ~ref_clk;
    // Short timer values keep the run brief
    six_channel_gate_control_logic #(.OffLongCyc(200), .RetryShortCyc(300), .RetryLongCyc(600))
    dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .chipResetLow(chipResetLow),
        .selectLow(selectLow), .serialClk(serialClk), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn),
        .channelCommandPin(channelCommandPin), .drainHighDetect(drainHighDetect),
        .drainLowDetect(drainLowDetect), .drainOpenDetect(drainOpenDetect),
        .supplyLowDetect(supplyLowDetect), .overheatDetect(overheatDetect),
        .gateOutput(gateOutput), .stbLevel(stbLevel), .stgLevel(stgLevel),
        .pullDownOff(pullDownOff)
    );
    serial_host_model host_u (
        .ref_clk(ref_clk), .selectLow(selectLow), .serialClk(serialClk),
        .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn)
    );
    // ----
    // Checking and closing
    // ----
    task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp)
        begin
            errTotal++;
            $display("[ERR] %0t readback %h, want %h", $time, got, exp);
        end
    endtask
    task automatic chkVec(input logic [17:0] got, input logic [17:0] exp);
        nTests++;
        if (got !== exp)
        begin
            errTotal++;
            $display("[ERR] %0t outputs %h, want %h", $time, got, exp);
        end
    endtask
    task automatic gateIs(input logic [5:0] e);
        chkVec({12'h000, gateOutput}, {12'h000, e});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycleCnt <= cycleCnt + 1;
        if (cycleCnt == 10000)
        begin
            errTotal++;
            close_out();
        end
    end
    // ----
    // Scenarios
    // ----
    task automatic t_defaults();
        gateIs(6'h00);
        chkVec(stbLevel, 18'h00000);
        chkVec({6'h00, stgLevel, pullDownOff}, 18'h00000);
        supplyLowDetect <= 1'b1;
        idle(4);
        host_u.xfer(16'h9000, 16, rx);
        chkWord(rx, 16'hc000);
        supplyLowDetect <= 1'b0;
        overheatDetect <= 1'b1;
        idle(4);
        host_u.xfer(16'h1000, 16, rx);
        chkWord(rx, 16'h3000);
        overheatDetect <= 1'b0;
    endtask
    task automatic t_gates();
        host_u.xfer(16'h003f, 16, rx);
        idle(10);
        gateIs(6'h3f);
        host_u.xfer(16'h0004, 16, rx);
        channelCommandPin <= 6'h21;
        idle(10);
        gateIs(6'h25);
        host_u.xfer(16'h0000, 16, rx);
        channelCommandPin <= 6'h00;
        idle(10);
        gateIs(6'h00);
        host_u.xfer(16'h003f, 15, rx);
        idle(10);
        gateIs(6'h00);
    endtask
    task automatic t_cfg();
        logic [11:0] d;
        logic [17:0] eStb;
        logic [5:0] eSg;
        logic [5:0] eNpd;
        for (int p = 0; p < 2; p++)
        begin
            for (int k = 0; k < CH_N; k++)
            begin
                d = 12'h000;
                d[CFG_NPD] = p[0];
                d[CFG_SB_LSB+:3] = 3'(k + 2 * p);
                d[CFG_SG] = k[0];
                eStb[3*k+:3] = d[CFG_SB_LSB+:3];
                eSg[k] = d[CFG_SG];
                eNpd[k] = d[CFG_NPD];
                host_u.xfer({ADDR_CFG0 + 4'(k), d}, 16, rx);
            end
            chkVec(stbLevel, eStb);
            chkVec({6'h00, stgLevel, pullDownOff}, {6'h00, eSg, eNpd});
        end
    endtask
    task automatic t_fault();
        host_u.xfer(16'h1004, 16, rx);
        channelCommandPin <= 6'h06;
        drainHighDetect <= 6'h06;
        idle(300);
        gateIs(6'h04);
        host_u.xfer(16'h0000, 16, rx);
        chkWord(rx, 16'h0008);
        drainHighDetect <= 6'h00;
        chipResetLow <= 1'b0;
        idle(20);
        chipResetLow <= 1'b1;
        idle(20);
        gateIs(6'h04);
        chipResetLow <= 1'b0;
        idle(60);
        gateIs(6'h00);
        chipResetLow <= 1'b1;
        idle(20);
        gateIs(6'h06);
        host_u.xfer(16'h0000, 16, rx);
        chkWord(rx, 16'h8000);
        channelCommandPin <= 6'h00;
    endtask
    task automatic t_retry();
        host_u.xfer(16'h7800, 16, rx);
        channelCommandPin <= 6'h20;
        drainHighDetect <= 6'h20;
        drainLowDetect <= 6'h08;
        idle(200);
        gateIs(6'h00);
        host_u.xfer(16'h9000, 16, rx);
        chkWord(rx, 16'h0000);
        gateIs(6'h00);
        drainHighDetect <= 6'h00;
        drainLowDetect <= 6'h00;
        host_u.xfer(16'h9000, 16, rx);
        chkWord(rx, 16'h1042);
        idle(20);
        gateIs(6'h20);
        idle(100);
        host_u.xfer(16'h9000, 16, rx);
        chkWord(rx, 16'h1042);
        host_u.xfer(16'h0000, 16, rx);
        chkWord(rx, 16'h1002);
        channelCommandPin <= 6'h00;
    endtask
    initial
    begin
        idle(10);
        arst_n <= 1'b1;
        idle(10);
        t_defaults();
        t_gates();
        t_cfg();
        t_fault();
        t_retry();
        close_out();
    end
endmodule // tb_six_channel_gate_control_logic
`default_nettype wire
